// >>> two_wire_pkg.sv
/*
 * constants for the two-wire slave: register indices, field positions,
 * reset values, status codes, timing and the controller state type.
 * assumes a 50 MHz system clock.
 */
`default_nettype none
package two_wire_pkg;
	// --------------------------------------------------------------------
	// register indices on the software port
	// --------------------------------------------------------------------
	localparam logic [1:0] CTRL_IDX   = 2'h0;
	localparam logic [1:0] STATUS_IDX = 2'h1;
	localparam logic [1:0] OWN_IDX    = 2'h2;
	localparam logic [1:0] DATA_IDX   = 2'h3;
	// --------------------------------------------------------------------
	// control register fields, then the general call enable bit of the own-address register
	// --------------------------------------------------------------------
	localparam int FLAG_BIT  = 7;
	localparam int ACK_BIT   = 6;
	localparam int START_BIT = 5;
	localparam int STOP_BIT  = 4;
	localparam int WCOL_BIT  = 3;
	localparam int EN_BIT    = 2;
	localparam int IE_BIT    = 0;
	localparam int GCE_BIT   = 0;
	// --------------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------------
	localparam logic [7:0] OWN_RST   = 8'h00;
	localparam logic [7:0] DATA_RST  = 8'hff;
	localparam logic [1:0] PRESC_RST = 2'h0;
	// --------------------------------------------------------------------
	// status codes
	// --------------------------------------------------------------------
	localparam logic [7:0] ST_BUS_ERR  = 8'h00;
	localparam logic [7:0] ST_SRW_OWN  = 8'h60;
	localparam logic [7:0] ST_SRW_ARB  = 8'h68;
	localparam logic [7:0] ST_SRW_GC   = 8'h70;
	localparam logic [7:0] ST_SRW_GCA  = 8'h78;
	localparam logic [7:0] ST_RX_ACK   = 8'h80;
	localparam logic [7:0] ST_RX_NACK  = 8'h88;
	localparam logic [7:0] ST_GRX_ACK  = 8'h90;
	localparam logic [7:0] ST_GRX_NACK = 8'h98;
	localparam logic [7:0] ST_STOP     = 8'ha0;
	localparam logic [7:0] ST_SRR_OWN  = 8'ha8;
	localparam logic [7:0] ST_SRR_ARB  = 8'hb0;
	localparam logic [7:0] ST_TX_ACK   = 8'hb8;
	localparam logic [7:0] ST_TX_NACK  = 8'hc0;
	localparam logic [7:0] ST_TX_LAST  = 8'hc8;
	localparam logic [7:0] ST_NONE     = 8'hf8;
	localparam logic [7:0] GC_ADDR     = 8'h00;
	// --------------------------------------------------------------------
	// timing
	// --------------------------------------------------------------------
	localparam int CLK_MHZ       = 50;
	localparam int START_HOLD_NS = 4000;
	localparam int START_HOLD_CYC = (START_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// --------------------------------------------------------------------
	// controller states
	// --------------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_WAIT, S_TX, S_TX_ACK, S_RX, S_RX_ACK
	} state_t;
endpackage
`default_nettype wire

// >>> pin_sync.sv
/*
 * three-stage synchroniser for one bus pin; the output level changes
 * only once the second and third stages agree.
 * assumes the pin idles high (open drain with pull-up).
 */
`default_nettype none
module pin_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output var  logic level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_nxt;

	always_comb begin
		level_nxt = level;
		if (s2_r == s3_r) begin
			level_nxt = s3_r;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_r  <= 1'b1;
			s2_r  <= 1'b1;
			s3_r  <= 1'b1;
			level <= 1'b1;
		end else begin
			s1_r  <= pin;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			level <= level_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> two_wire_slave_transmitter.sv
/*
 * slave side of the two-wire serial unit: address recognition, slave
 * transmit and receive byte handling, status codes, register port.
 * assumes pins sampled on clk, open-drain pads resolved outside, and a
 * separate master section that takes over after start_sent.
 */
`default_nettype none
// Overview of operation
// - stop or repeated start while addressed sets flag, status 0xa0 only at a received byte's first bit, else 0x00.
// - clearing after 0xa0 with start 0, ack 0 ignores own and general call.
// - with ack 1, own address recognised; general call only if enabled.
// - start request at clear sends a start once the bus is free.
// - upper seven own-address bits give the slave address.
// - own-address bit 0 enables response to general call 0x00.
// - read bit selects transmit mode, write bit selects receive mode.
// - after own address and direction, flag set with valid status.
// - addressed for read after lost arbitration reports 0xb0.
// - ack cleared sends last byte; nack gives 0xc0, ack gives 0xc8.
// - after last byte go not addressed; master then reads ones.
// - ack 0 ignores own address but keeps watching; resumes when set.
// - in deep sleep, address still acknowledged, then the part wakes.
// - after wake-up scl held low until software clears the flag.
// - data register not updated by bus while in deep sleep.
// - on 0xa8 software loads byte and picks ack for last or more.
// - acked byte gives 0xb8 unless sent as last, nacked byte gives 0xc0.
// - bus error 0x00 with stop request releases lines, not addressed.
module two_wire_slave_transmitter (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	input  wire logic       scl_in,
	output var  logic       scl_out,
	output var  logic       scl_oe,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	input  wire logic       deep_sleep,
	input  wire logic       arb_lost,
	output var  logic       wake_req,
	output var  logic       start_sent
);
	// --------------------------------------------------------------------
	// pin sampling and bus events
	// --------------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	logic scl_p_r;
	logic sda_p_r;

	pin_sync u_scl_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (scl_in),
		.level (scl_s)
	);
	pin_sync u_sda_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (sda_in),
		.level (sda_s)
	);

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise  = scl_s & ~scl_p_r;
	assign scl_fall  = ~scl_s & scl_p_r;
	assign start_det = scl_s & scl_p_r & sda_p_r & ~sda_s;
	assign stop_det  = scl_s & scl_p_r & ~sda_p_r & sda_s;

	// --------------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------------
	function automatic logic [1:0] addr_hit(input logic [7:0] rx, input logic [7:0] own,
	                                        input logic ack);
		logic own_hit;
		logic gc_hit;
		own_hit  = ack & (rx[7:1] == own[7:1]);
		gc_hit   = ack & own[two_wire_pkg::GCE_BIT]
		           & (rx[7:1] == two_wire_pkg::GC_ADDR[7:1]);
		addr_hit = {gc_hit & ~own_hit, own_hit};
	endfunction

	// --------------------------------------------------------------------
	// state
	// --------------------------------------------------------------------
	two_wire_pkg::state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic       sda_drv_r, sda_drv_nxt;
	logic       flag_r, flag_nxt;
	logic       ack_en_r, ack_en_nxt;
	logic       start_r, start_nxt;
	logic       stop_r, stop_nxt;
	logic       en_r, en_nxt;
	logic       ie_r, ie_nxt;
	logic       wcol_r, wcol_nxt;
	logic [7:0] own_r, own_nxt;
	logic [7:0] data_r, data_nxt;
	logic [7:0] code_r, code_nxt;
	logic [1:0] presc_r, presc_nxt;
	logic       last_r, last_nxt;
	logic       gc_r, gc_nxt;
	logic       dir_r, dir_nxt;
	logic       ackd_r, ackd_nxt;
	logic       arb_r, arb_nxt;
	logic       busy_r, busy_nxt;
	logic       sta_drv_r, sta_drv_nxt;
	logic [7:0] sta_cnt_r, sta_cnt_nxt;
	logic       sent_r, sent_nxt;
	logic       wake_r, wake_nxt;
	logic [7:0] rdata_nxt;

	logic       wr_ctrl;
	logic       flag_clr;
	logic [1:0] hit;
	logic [7:0] shifted_in;
	assign wr_ctrl    = reg_wr & (reg_addr == two_wire_pkg::CTRL_IDX);
	assign flag_clr   = wr_ctrl & reg_wdata[two_wire_pkg::FLAG_BIT] & flag_r;
	assign shifted_in = {shift_r[6:0], sda_s};
	assign hit        = addr_hit(shift_r, own_r, ack_en_r);

	always_comb begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		shift_nxt   = shift_r;
		sda_drv_nxt = sda_drv_r;
		flag_nxt    = flag_r;
		ack_en_nxt  = ack_en_r;
		start_nxt   = start_r;
		stop_nxt    = stop_r;
		en_nxt      = en_r;
		ie_nxt      = ie_r;
		wcol_nxt    = wcol_r;
		own_nxt     = own_r;
		data_nxt    = data_r;
		code_nxt    = code_r;
		presc_nxt   = presc_r;
		last_nxt    = last_r;
		gc_nxt      = gc_r;
		dir_nxt     = dir_r;
		ackd_nxt    = ackd_r;
		arb_nxt     = arb_r | arb_lost;
		busy_nxt    = busy_r;
		sta_drv_nxt = sta_drv_r;
		sta_cnt_nxt = sta_cnt_r;
		sent_nxt    = 1'b0;
		wake_nxt    = 1'b0;

		// software writes; hardware flag events below override the clear
		if (wr_ctrl) begin
			ack_en_nxt = reg_wdata[two_wire_pkg::ACK_BIT];
			start_nxt  = reg_wdata[two_wire_pkg::START_BIT];
			stop_nxt   = reg_wdata[two_wire_pkg::STOP_BIT];
			en_nxt     = reg_wdata[two_wire_pkg::EN_BIT];
			ie_nxt     = reg_wdata[two_wire_pkg::IE_BIT];
			if (flag_clr) begin
				flag_nxt = 1'b0;
			end
		end
		if (reg_wr && reg_addr == two_wire_pkg::STATUS_IDX) begin
			presc_nxt = reg_wdata[1:0];
		end
		if (reg_wr && reg_addr == two_wire_pkg::OWN_IDX) begin
			own_nxt = reg_wdata;
		end
		if (reg_wr && reg_addr == two_wire_pkg::DATA_IDX) begin
			// a write while the bus is mid-byte would corrupt the frame
			if (flag_r) begin
				data_nxt = reg_wdata;
				wcol_nxt = 1'b0;
			end else begin
				wcol_nxt = 1'b1;
			end
		end

		if (start_det) begin
			busy_nxt = 1'b1;
		end
		if (stop_det) begin
			busy_nxt = 1'b0;
			arb_nxt  = arb_lost;                                      // a loss in the same cycle wins
		end
		if (scl_rise) begin
			cnt_nxt = cnt_r + 4'h1;
		end

		case (state_r)
			two_wire_pkg::S_IDLE: begin
				sda_drv_nxt = 1'b0;
				if (start_det) begin
					state_nxt = two_wire_pkg::S_ADDR;
					cnt_nxt   = 4'h0;
				end
			end
			two_wire_pkg::S_ADDR: begin
				if (scl_rise) begin
					shift_nxt = shifted_in;
				end
				if (scl_fall && cnt_r == two_wire_pkg::BITS_PER_BYTE) begin
					cnt_nxt = 4'h0;
					if (hit != 2'b00 && !flag_r) begin
						state_nxt   = two_wire_pkg::S_ADDR_ACK;
						sda_drv_nxt = 1'b1;
						gc_nxt      = hit[1];
						dir_nxt     = shift_r[0];
					end else begin
						state_nxt = two_wire_pkg::S_IDLE;
					end
				end
			end
			two_wire_pkg::S_ADDR_ACK: begin
				if (scl_fall) begin
					sda_drv_nxt = 1'b0;
					cnt_nxt     = 4'h0;
					flag_nxt    = 1'b1;
					state_nxt   = two_wire_pkg::S_WAIT;
					wake_nxt    = deep_sleep;
					if (dir_r) begin
						code_nxt = arb_r ? two_wire_pkg::ST_SRR_ARB
						                 : two_wire_pkg::ST_SRR_OWN;
					end else if (gc_r) begin
						code_nxt = arb_r ? two_wire_pkg::ST_SRW_GCA : two_wire_pkg::ST_SRW_GC;
					end else begin
						code_nxt = arb_r ? two_wire_pkg::ST_SRW_ARB
						                 : two_wire_pkg::ST_SRW_OWN;
					end
				end
			end
			two_wire_pkg::S_WAIT: begin
				// scl is stretched while the flag stands
				if (flag_clr) begin
					cnt_nxt = 4'h0;
					if (reg_wdata[two_wire_pkg::STOP_BIT]) begin
						state_nxt   = two_wire_pkg::S_IDLE;
						stop_nxt    = 1'b0;
						sda_drv_nxt = 1'b0;
					end else begin
						case (code_r)
							two_wire_pkg::ST_SRR_OWN, two_wire_pkg::ST_SRR_ARB,
							two_wire_pkg::ST_TX_ACK: begin
								state_nxt   = two_wire_pkg::S_TX;
								shift_nxt   = data_r;
								sda_drv_nxt = ~data_r[7];
								last_nxt    = ~reg_wdata[two_wire_pkg::ACK_BIT];
							end
							two_wire_pkg::ST_SRW_OWN, two_wire_pkg::ST_SRW_ARB,
							two_wire_pkg::ST_SRW_GC, two_wire_pkg::ST_SRW_GCA,
							two_wire_pkg::ST_RX_ACK, two_wire_pkg::ST_GRX_ACK: begin
								state_nxt = two_wire_pkg::S_RX;
							end
							default: begin
								state_nxt = two_wire_pkg::S_IDLE;
							end
						endcase
					end
				end
			end
			two_wire_pkg::S_TX: begin
				if (scl_fall) begin
					shift_nxt = {shift_r[6:0], 1'b1};
					if (cnt_r == two_wire_pkg::BITS_PER_BYTE) begin
						state_nxt   = two_wire_pkg::S_TX_ACK;
						sda_drv_nxt = 1'b0;
						cnt_nxt     = 4'h0;
					end else begin
						sda_drv_nxt = ~shift_r[6];
					end
				end
			end
			two_wire_pkg::S_TX_ACK: begin
				if (scl_rise) begin
					ackd_nxt = ~sda_s;
				end
				if (scl_fall) begin
					flag_nxt  = 1'b1;
					state_nxt = two_wire_pkg::S_WAIT;
					cnt_nxt   = 4'h0;
					if (!ackd_r) begin
						code_nxt = two_wire_pkg::ST_TX_NACK;
					end else if (last_r) begin
						code_nxt = two_wire_pkg::ST_TX_LAST;
					end else begin
						code_nxt = two_wire_pkg::ST_TX_ACK;
					end
				end
			end
			two_wire_pkg::S_RX: begin
				if (scl_rise) begin
					shift_nxt = shifted_in;
				end
				if (scl_fall && cnt_r == two_wire_pkg::BITS_PER_BYTE) begin
					state_nxt   = two_wire_pkg::S_RX_ACK;
					sda_drv_nxt = ack_en_r;
					ackd_nxt    = ack_en_r;
					cnt_nxt     = 4'h0;
				end
			end
			two_wire_pkg::S_RX_ACK: begin
				if (scl_fall) begin
					sda_drv_nxt = 1'b0;
					flag_nxt    = 1'b1;
					state_nxt   = two_wire_pkg::S_WAIT;
					cnt_nxt     = 4'h0;
					if (!deep_sleep) begin
						data_nxt = shift_r;
					end
					if (gc_r) begin
						code_nxt = ackd_r ? two_wire_pkg::ST_GRX_ACK : two_wire_pkg::ST_GRX_NACK;
					end else begin
						code_nxt = ackd_r ? two_wire_pkg::ST_RX_ACK : two_wire_pkg::ST_RX_NACK;
					end
				end
			end
			default: begin
				state_nxt = two_wire_pkg::S_IDLE;
			end
		endcase

		// stop or start inside an addressed frame
		if ((start_det || stop_det) && state_r != two_wire_pkg::S_IDLE
		    && state_r != two_wire_pkg::S_ADDR && state_r != two_wire_pkg::S_WAIT) begin
			flag_nxt    = 1'b1;
			sda_drv_nxt = 1'b0;
			state_nxt   = two_wire_pkg::S_WAIT;
			cnt_nxt     = 4'h0;
			// a stop or restart gives 0xa0 only in receive just after the first clock of a byte, else 0x00
			if (state_r == two_wire_pkg::S_RX && cnt_r == 4'h1) begin
				code_nxt = two_wire_pkg::ST_STOP;
			end else begin
				code_nxt = two_wire_pkg::ST_BUS_ERR;
			end
		end

		// start launch once the bus is free
		if (sta_drv_r) begin
			if (sta_cnt_r == 8'(two_wire_pkg::START_HOLD_CYC - 1)) begin
				sta_drv_nxt = 1'b0;
				sent_nxt    = 1'b1;
				start_nxt   = 1'b0;
			end else begin
				sta_cnt_nxt = sta_cnt_r + 8'h01;
			end
		end else if (start_r && en_r && !busy_r && !flag_r
		             && state_r == two_wire_pkg::S_IDLE) begin
			sta_drv_nxt = 1'b1;
			sta_cnt_nxt = 8'h00;
		end

		if (!en_r) begin
			state_nxt   = two_wire_pkg::S_IDLE;
			sda_drv_nxt = 1'b0;
			sta_drv_nxt = 1'b0;
		end
	end

	// --------------------------------------------------------------------
	// register read mux
	// --------------------------------------------------------------------
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				two_wire_pkg::CTRL_IDX: rdata_nxt = {flag_r, ack_en_r, start_r, stop_r,
				                                     wcol_r, en_r, 1'b0, ie_r};
				two_wire_pkg::STATUS_IDX: begin
					rdata_nxt = {(flag_r ? code_r[7:3] : two_wire_pkg::ST_NONE[7:3]),
					             1'b0, presc_r};
				end
				two_wire_pkg::OWN_IDX:  rdata_nxt = own_r;
				default:                rdata_nxt = data_r;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r   <= two_wire_pkg::S_IDLE;
			cnt_r     <= 4'h0;
			shift_r   <= 8'h00;
			sda_drv_r <= 1'b0;
			flag_r    <= 1'b0;
			ack_en_r  <= 1'b0;
			start_r   <= 1'b0;
			stop_r    <= 1'b0;
			en_r      <= 1'b0;
			ie_r      <= 1'b0;
			wcol_r    <= 1'b0;
			own_r     <= two_wire_pkg::OWN_RST;
			data_r    <= two_wire_pkg::DATA_RST;
			code_r    <= two_wire_pkg::ST_NONE;
			presc_r   <= two_wire_pkg::PRESC_RST;
			last_r    <= 1'b0;
			gc_r      <= 1'b0;
			dir_r     <= 1'b0;
			ackd_r    <= 1'b0;
			arb_r     <= 1'b0;
			busy_r    <= 1'b0;
			sta_drv_r <= 1'b0;
			sta_cnt_r <= 8'h00;
			sent_r    <= 1'b0;
			wake_r    <= 1'b0;
			scl_p_r   <= 1'b1;
			sda_p_r   <= 1'b1;
			reg_rdata <= 8'h00;
		end else begin
			state_r   <= state_nxt;
			cnt_r     <= cnt_nxt;
			shift_r   <= shift_nxt;
			sda_drv_r <= sda_drv_nxt;
			flag_r    <= flag_nxt;
			ack_en_r  <= ack_en_nxt;
			start_r   <= start_nxt;
			stop_r    <= stop_nxt;
			en_r      <= en_nxt;
			ie_r      <= ie_nxt;
			wcol_r    <= wcol_nxt;
			own_r     <= own_nxt;
			data_r    <= data_nxt;
			code_r    <= code_nxt;
			presc_r   <= presc_nxt;
			last_r    <= last_nxt;
			gc_r      <= gc_nxt;
			dir_r     <= dir_nxt;
			ackd_r    <= ackd_nxt;
			arb_r     <= arb_nxt;
			busy_r    <= busy_nxt;
			sta_drv_r <= sta_drv_nxt;
			sta_cnt_r <= sta_cnt_nxt;
			sent_r    <= sent_nxt;
			wake_r    <= wake_nxt;
			scl_p_r   <= scl_s;
			sda_p_r   <= sda_s;
			reg_rdata <= rdata_nxt;
		end
	end

	// --------------------------------------------------------------------
	// pads; open drain so only low is ever driven
	// --------------------------------------------------------------------
	assign scl_out    = 1'b0;
	assign scl_oe     = flag_r & (state_r == two_wire_pkg::S_WAIT);
	assign sda_out    = 1'b0;
	assign sda_oe     = sda_drv_r | sta_drv_r;
	assign wake_req   = wake_r;
	assign start_sent = sent_r;
endmodule
`default_nettype wire

// >>> two_wire_slave_transmitter_properties.sv
/*
 * port checker for the two-wire slave, bound into its top module.
 * assumes one clock domain and the synchronous active-low reset.
 */
`default_nettype none
module two_wire_slave_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       deep_sleep,
	input wire logic       wake_req,
	input wire logic       start_sent
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// length of the current data-low drive
	// ------------------------------------------------------------
	logic [8:0] hold_r;
	logic [8:0] hold_nxt;
	always_comb hold_nxt = sda_oe ? hold_r + 9'h001 : 9'h000;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_r <= 9'h000;
		end else begin
			hold_r <= hold_nxt;
		end
	end
	sequence own_write;
		reg_wr && reg_addr == two_wire_pkg::OWN_IDX;
	endsequence
	sequence own_read;
		reg_rd && reg_addr == two_wire_pkg::OWN_IDX;
	endsequence
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	status_res_a: assert property (
		reg_rd && reg_addr == two_wire_pkg::STATUS_IDX |=> !reg_rdata[2])
		else $error("status reserved bit set");
	own_back_a: assert property (
		own_write ##1 !reg_wr ##1 own_read |=> reg_rdata == $past(reg_wdata, 3))
		else $error("own address read back differs");
	stretch_hold_a: assert property (
		scl_oe && !(reg_wr && reg_addr == two_wire_pkg::CTRL_IDX) |=> scl_oe)
		else $error("clock released without a control write");
	wake_pulse_a: assert property (wake_req |-> $past(deep_sleep) ##1 !wake_req)
		else $error("wake request outside sleep or too long");
	wake_hold_a: assert property (wake_req |-> ##[0:8] scl_oe)
		else $error("clock not held after wake");
	start_pulse_a: assert property (start_sent |=> !start_sent)
		else $error("start pulse too long");
	start_hold_a: assert property (start_sent |-> hold_r >= 9'(two_wire_pkg::START_HOLD_CYC))
		else $error("start sent without data held low");
	pads_low_a: assert property (!scl_out && !sda_out)
		else $error("pad drives high");
endmodule
bind two_wire_slave_transmitter two_wire_slave_checker two_wire_slave_checker_i (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .deep_sleep(deep_sleep),
	.wake_req(wake_req), .start_sent(start_sent)
);
`default_nettype wire

// >>> bus_master_model.sv
/*
 * two-wire bus master: start, stop and nine-bit transfers, a bus clock
 * of 160 ns: five system cycles low, three high.
 * assumes pull-ups on both wires; the bench calls the tasks.
 */
`default_nettype none
module bus_master_model (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_low,
	output var  logic sda_low,
	output var  logic stuck
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_low = 1'h0;
		sda_low = 1'h0;
		stuck = 1'h0;
	end
	task automatic half();
		repeat (4) @(posedge clk);
	endtask
	// ------------------------------------------------------------
	// conditions; also a repeated start from a low clock
	// ------------------------------------------------------------
	task automatic start_cond();
		@(posedge clk);
		sda_low <= 1'h0;
		half();
		scl_low <= 1'h0;
		half();
		sda_low <= 1'h1;
		half();
		scl_low <= 1'h1;
	endtask
	task automatic stop_cond();
		@(posedge clk);
		sda_low <= 1'h1;
		half();
		scl_low <= 1'h0;
		half();
		sda_low <= 1'h0;
		half();
	endtask
	// msb first; a 1 leaves the wire to the slave
	task automatic xfer(input logic [8:0] o, output logic [8:0] r);
		int n;
		for (int i = 8; i >= 0; i--) begin
			@(posedge clk);
			sda_low <= ~o[i]; // ninth bit: ack or nack
			half();
			scl_low <= 1'h0;
			n = 0;
			@(posedge clk);
			while (!scl && n < 4000) begin
				@(posedge clk);
				n++;
			end
			stuck <= stuck | ~scl;
			repeat (2) @(posedge clk);
			r[i] = sda;
			scl_low <= 1'h1;
		end
	endtask
endmodule
`default_nettype wire

// >>> test_two_wire_slave_transmitter.sv
/*
 * bench for the two-wire slave: register tasks and a bus master model.
 * assumes pull-ups on both wires, modelled by the wired-and below.
 */
`default_nettype none
module test_two_wire_slave_transmitter;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'h0;
	logic       rst_n = 1'h0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'h0;
	logic       reg_rd = 1'h0;
	logic       deep_sleep = 1'h0;
	logic       arb_lost = 1'h0;
	logic [7:0] reg_rdata;
	logic       scl_out, scl_oe, sda_out, sda_oe, wake_req, start_sent;
	logic       scl_low, sda_low, stuck;
	wire logic  scl = ~(scl_low | (scl_oe & ~scl_out));
	wire logic  sda = ~(sda_low | (sda_oe & ~sda_out));
	logic [8:0] rx;
	int         num_errors = 0;
	int         checked = 0;
	int         wakes = 0;
	int         starts = 0;
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (wake_req === 1'h1) wakes <= wakes + 1;
		if (start_sent === 1'h1) starts <= starts + 1;
	end
	two_wire_slave_transmitter two_wire_slave_transmitter_i (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .deep_sleep(deep_sleep), .arb_lost(arb_lost),
		.wake_req(wake_req), .start_sent(start_sent)
	);
	bus_master_model bus_master_model_i (
		.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low),
		.stuck(stuck)
	);
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// a gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [1:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
		@(posedge clk);
		if (what != "") check(what, d, exp);
		else rx[7:0] = d;
	endtask
	task automatic wait_flag();
		int n;
		n = 0;
		rx = 9'h000;
		while (rx[7] !== 1'h1) begin
			rdchk(two_wire_pkg::CTRL_IDX, 8'h00, "");
			n++;
			if (n > 2000) begin
				num_errors++;
				summarize();
			end
		end
	endtask
	task automatic addr(input logic [7:0] a, input logic ack, input logic [7:0] st);
		bus_master_model_i.start_cond();
		bus_master_model_i.xfer({a, 1'h1}, rx);
		check("address ack", {7'h00, rx[0]}, {7'h00, ~ack});
		if (st !== 8'hf8) wait_flag();
		else repeat (8) @(posedge clk);
		rdchk(two_wire_pkg::STATUS_IDX, st, "status");
	endtask
	task automatic get(input logic [7:0] d, input logic [7:0] c, input logic mack,
		input logic [7:0] exp_d, input logic [7:0] st);
		wr(two_wire_pkg::DATA_IDX, d);
		wr(two_wire_pkg::CTRL_IDX, c);
		bus_master_model_i.xfer({8'hff, ~mack}, rx);
		check("byte read", rx[8:1], exp_d);
		if (st !== 8'hf8) wait_flag();
		else repeat (8) @(posedge clk);
		rdchk(two_wire_pkg::STATUS_IDX, st, "status");
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] rst_tab [4] = '{8'h00, 8'hf8, 8'h00, 8'hff};
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 4; i++) rdchk(2'(i), rst_tab[i], "reset value");
		wr(two_wire_pkg::OWN_IDX, 8'ha5);
		rdchk(two_wire_pkg::OWN_IDX, 8'ha5, "own address");
		wr(two_wire_pkg::CTRL_IDX, 8'h44);
		addr(8'ha5, 1'h1, 8'ha8);
		check("clock held", {7'h00, scl_oe}, 8'h01);
		get(8'h3c, 8'hc4, 1'h1, 8'h3c, 8'hb8);
		get(8'h5a, 8'h84, 1'h1, 8'h5a, 8'hc8);
		get(8'h00, 8'hc4, 1'h1, 8'hff, 8'hf8);
		bus_master_model_i.stop_cond();
		addr(8'ha5, 1'h1, 8'ha8);
		get(8'h0f, 8'hc4, 1'h0, 8'h0f, 8'hc0);
		wr(two_wire_pkg::CTRL_IDX, 8'h84);
		bus_master_model_i.stop_cond();
		addr(8'ha5, 1'h0, 8'hf8);
		bus_master_model_i.stop_cond();
		wr(two_wire_pkg::CTRL_IDX, 8'h44);
		addr(8'h00, 1'h1, 8'h70);
		wr(two_wire_pkg::CTRL_IDX, 8'hc4);
		bus_master_model_i.stop_cond();
		wait_flag();
		rdchk(two_wire_pkg::STATUS_IDX, 8'ha0, "stop status");
		wr(two_wire_pkg::OWN_IDX, 8'ha4);
		wr(two_wire_pkg::CTRL_IDX, 8'hc4);
		addr(8'h00, 1'h0, 8'hf8);
		bus_master_model_i.stop_cond();
		arb_lost <= 1'h1;
		@(posedge clk);
		arb_lost <= 1'h0;
		addr(8'ha5, 1'h1, 8'hb0);
		get(8'h81, 8'h84, 1'h0, 8'h81, 8'hc0);
		wr(two_wire_pkg::CTRL_IDX, 8'hc4);
		bus_master_model_i.stop_cond();
		addr(8'ha5, 1'h1, 8'ha8);
		wr(two_wire_pkg::DATA_IDX, 8'hf0);
		wr(two_wire_pkg::CTRL_IDX, 8'hc4);
		bus_master_model_i.stop_cond();
		wait_flag();
		rdchk(two_wire_pkg::STATUS_IDX, 8'h00, "bus error");
		wr(two_wire_pkg::CTRL_IDX, 8'hd4);
		rdchk(two_wire_pkg::CTRL_IDX, 8'h44, "error recovery");
		deep_sleep <= 1'h1;
		addr(8'ha5, 1'h1, 8'ha8);
		check("wake pulses", 8'(wakes), 8'h01);
		check("clock held", {7'h00, scl_oe}, 8'h01);
		deep_sleep <= 1'h0;
		get(8'h77, 8'h84, 1'h0, 8'h77, 8'hc0);
		wr(two_wire_pkg::CTRL_IDX, 8'he4);
		check("early start", 8'(starts), 8'h00);
		bus_master_model_i.stop_cond();
		for (int n = 0; n < 1000 && starts == 0; n++) @(posedge clk);
		check("start sent", 8'(starts), 8'h01);
		rdchk(two_wire_pkg::CTRL_IDX, 8'h44, "start request");
		check("clock free", {7'h00, stuck}, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
